// *** design/reader_direct_command_decoder.sv ***
// Purpose: Direct command decoder of a reader front end, APB slave
// Assumes: Host words arrive as whole APB writes; 250 MHz clock
// Notes:   Zero wait state slave; unmapped addresses answer PSLVERR
//
// Overview of operation
// - Host word top bit set means command, clear means register address.
// - Command code in low five bits; read and continuous bits must be zero.
// - Address word: bit six read, bit five continuous, low five bits address.
// - Software initialization code performs the full power-on reset.
// - Initial collision avoidance turns field on, interrupts 5 ms after it.
// - External field above low-field level blocks field and raises failure flag.
// - Response collision avoidance interrupts 75 us after field established.
// - Response variant without random delay, same 75 us interrupt.
// - Reset command empties FIFO, its status, and collision position.
// - Immediate transmission starts once first byte sits in FIFO.
// - CRC codes append CRC; plain codes send payload without CRC.
// - Delayed transmission waits for the transmit timer to expire.
// - Next-slot command sends the protocol's next-slot marker.
// - Block receiver holds bit decoder and framer in reset.
// - Receiver reset ends on enable receiver or end of transmit.
// - Nonzero receive wait time delays release after transmit.
// - Internal RF test stores both input level codes in RSSI register.
// - Close slot, external RF test, gain adjust and idle also decoded.
// - Interrupt status holds collision success and failure bits.
// - Interrupt status clears at end of host read, withdrawing request.
`timescale 1ns/10ps
`default_nettype none
module reader_direct_command_decoder
  import reader_cmd_pkg::*;
#(
  parameter int INIT_CYC = reader_cmd_pkg::INIT_WAIT_CYC,
  parameter int RESP_CYC = reader_cmd_pkg::RESP_WAIT_CYC
)(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Analog and link status
  input  wire logic [2:0]  EXT_FIELD_LEVEL,
  input  wire logic [11:0] PRIMARY_RF_INPUT,
  input  wire logic [11:0] SECONDARY_RF_INPUT,
  input  wire logic        FIFO_HAS_DATA,
  input  wire logic        TX_TIMER_EXPIRED,
  input  wire logic        TX_DONE,
  input  wire logic        COLL_POS_VALID,
  input  wire logic [7:0]  COLL_POS,
  // Reader actions
  output logic             CHIP_INIT,
  output logic             RF_ON,
  output logic             TX_START,
  output logic             TX_WITH_CRC,
  output logic             NEXT_SLOT,
  output logic             CLOSE_SLOT,
  output logic             EXT_RF_TEST,
  output logic             GAIN_ADJUST,
  output logic             FIFO_CLEAR,
  output logic             RX_RESET,
  // Interrupt request
  output logic             IRQ
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  ca_if ca ();
  logic        rst;
  logic        init_q;
  logic [5:0]  idx;
  logic        acc_w;
  logic        acc_r;
  logic        mapped;
  logic [7:0]  rx_wait_q;
  logic [7:0]  irq_q;
  logic [7:0]  coll_pos_q;
  logic [7:0]  rssi_q;
  logic [7:0]  low_field_q;
  logic [4:0]  ptr_q;
  logic        ptr_rd_q;
  logic        ptr_cont_q;
  logic        w_is_cmd;
  logic        w_cmd_ok;
  logic [4:0]  w_code;
  logic        w_rd;
  logic        w_cont;
  logic        cmd_go;
  logic        word_go;
  logic        data_acc;
  logic        tx_pend_q;
  logic        tx_delay_q;
  logic        tx_busy_q;
  logic        crc_q;
  logic        rx_block_q;
  logic [15:0] rx_wait_cnt_q;
  logic        rx_wait_run_q;
  logic [7:0]  rd_byte;
  logic        irq_rd;

  // Converts a peak level in mV to a code of 1 to 7
  function automatic logic [2:0] level_code(input logic [11:0] mv);
    logic [11:0] steps;
    steps = 12'(mv / 12'(RF_STEP_MV));
    if (steps < 12'h001) level_code = 3'h1;
    else if (steps > 12'h007) level_code = 3'h7;
    else level_code = steps[2:0];
  endfunction : level_code

  // Register write strobe, direct or through the address pointer
  function automatic logic reg_we(input logic [5:0] target);
    reg_we = (acc_w && idx == target) || (data_acc && PWRITE && {1'b0, ptr_q} == target);
  endfunction : reg_we

  // ---------------------------------------------------------------
  // Reset and bus decode
  // ---------------------------------------------------------------
  // Software init reuses the power-on path
  assign rst = RESET | init_q;

  assign idx      = PADDR[7:2];
  assign mapped   = idx == IDX_RX_WAIT || idx == IDX_IRQ || idx == IDX_COLL_POS ||
                    idx == IDX_RSSI || idx == IDX_LOW_FIELD || idx == IDX_HOST_WORD ||
                    idx == IDX_DATA || idx == IDX_STATUS;
  assign acc_w    = PSEL && PENABLE && PWRITE && mapped;
  assign acc_r    = PSEL && PENABLE && !PWRITE && mapped;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !mapped;
  assign word_go  = acc_w && idx == IDX_HOST_WORD;
  assign cmd_go   = word_go && w_cmd_ok;
  assign data_acc = PSEL && PENABLE && idx == IDX_DATA;
  assign irq_rd   = (acc_r && idx == IDX_IRQ) ||
                    (data_acc && !PWRITE && {1'b0, ptr_q} == IDX_IRQ);

  // Host word split
  host_word_decoder u_dec (
    .word   (PWDATA[7:0]),
    .is_cmd (w_is_cmd),
    .cmd_ok (w_cmd_ok),
    .code   (w_code),
    .rd     (w_rd),
    .cont   (w_cont)
  );

  // Collision avoidance timer
  collision_timer #(.INIT_CYC(INIT_CYC), .RESP_CYC(RESP_CYC)) u_ca (
    .clk (CLK),
    .rst (rst),
    .ca  (ca)
  );

  // Collision avoidance launch
  assign ca.start        = cmd_go && (w_code == CMD_CA_INIT || w_code == CMD_CA_RESP ||
                                      w_code == CMD_CA_RESP_N0);
  assign ca.long_wait    = w_code == CMD_CA_INIT;
  assign ca.random_delay = w_code == CMD_CA_RESP;
  assign ca.ext_level    = EXT_FIELD_LEVEL;
  assign ca.threshold    = low_field_q[2:0];
  assign RF_ON           = ca.rf_on;

  // ---------------------------------------------------------------
  // Software initialization
  // ---------------------------------------------------------------
  // One-cycle internal reset pulse
  always_ff @(posedge CLK) begin
    if (RESET) init_q <= 1'b0;
    else init_q <= cmd_go && w_code == CMD_SOFT_INIT;
  end
  assign CHIP_INIT = init_q;

  // ---------------------------------------------------------------
  // Address pointer
  // ---------------------------------------------------------------
  // Address words load the pointer, continuous mode steps it
  always_ff @(posedge CLK) begin
    if (rst) begin
      ptr_q      <= 5'h00;
      ptr_rd_q   <= 1'b0;
      ptr_cont_q <= 1'b0;
    end else if (word_go && !w_is_cmd) begin
      ptr_q      <= w_code;
      ptr_rd_q   <= w_rd;
      ptr_cont_q <= w_cont;
    end else if (data_acc && ptr_cont_q) begin
      ptr_q <= ptr_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Receive wait time and low-field level
  always_ff @(posedge CLK) begin
    if (rst) begin
      rx_wait_q   <= RST_BYTE;
      low_field_q <= RST_LOW_FIELD;
    end else begin
      if (reg_we(IDX_RX_WAIT)) rx_wait_q <= PWDATA[7:0];
      if (reg_we(IDX_LOW_FIELD)) low_field_q <= PWDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------
  // Interrupt status, a new event wins over the read clear
  always_ff @(posedge CLK) begin
    if (rst) irq_q <= RST_BYTE;
    else begin
      if (irq_rd) irq_q <= RST_BYTE;
      if (ca.done) irq_q[IRQ_COL_BIT] <= 1'b1;
      if (ca.fail) irq_q[IRQ_COL_ERR_BIT] <= 1'b1;
    end
  end
  assign IRQ = |irq_q;

  // Collision position
  always_ff @(posedge CLK) begin
    if (rst) coll_pos_q <= RST_BYTE;
    else if (cmd_go && w_code == CMD_RESET) coll_pos_q <= RST_BYTE;
    else if (COLL_POS_VALID) coll_pos_q <= COLL_POS;
  end

  // RSSI levels from the internal RF test
  always_ff @(posedge CLK) begin
    if (rst) rssi_q <= RST_BYTE;
    else if (cmd_go && w_code == CMD_RF_INT) begin
      rssi_q <= {2'h0, level_code(SECONDARY_RF_INPUT), level_code(PRIMARY_RF_INPUT)};
    end
  end

  // ---------------------------------------------------------------
  // Transmission control
  // ---------------------------------------------------------------
  // Pending frame, start condition and busy state
  always_ff @(posedge CLK) begin
    if (rst) begin
      tx_pend_q  <= 1'b0;
      tx_delay_q <= 1'b0;
      tx_busy_q  <= 1'b0;
      crc_q      <= 1'b0;
    end else if (cmd_go && w_code inside {CMD_TX_NOCRC, CMD_TX_CRC, CMD_DTX_NOCRC,
                                          CMD_DTX_CRC}) begin
      tx_pend_q  <= 1'b1;
      tx_delay_q <= w_code[1];
      crc_q      <= w_code[0];
    end else if (TX_START) begin
      tx_pend_q <= 1'b0;
      tx_busy_q <= 1'b1;
    end else if (TX_DONE) begin
      tx_busy_q <= 1'b0;
    end
  end
  assign TX_START    = tx_pend_q && FIFO_HAS_DATA && (!tx_delay_q || TX_TIMER_EXPIRED);
  assign TX_WITH_CRC = crc_q;

  // Single-cycle action strobes
  always_ff @(posedge CLK) begin
    if (rst) begin
      NEXT_SLOT   <= 1'b0;
      CLOSE_SLOT  <= 1'b0;
      EXT_RF_TEST <= 1'b0;
      GAIN_ADJUST <= 1'b0;
      FIFO_CLEAR  <= 1'b0;
    end else begin
      NEXT_SLOT   <= cmd_go && w_code == CMD_NEXT_SLOT;
      CLOSE_SLOT  <= cmd_go && w_code == CMD_CLOSE_SLOT;
      EXT_RF_TEST <= cmd_go && w_code == CMD_RF_EXT;
      GAIN_ADJUST <= cmd_go && w_code == CMD_GAIN_ADJ;
      FIFO_CLEAR  <= cmd_go && w_code == CMD_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Receiver block
  // ---------------------------------------------------------------
  // Blocked until enable, end of transmit, or end of wait time
  always_ff @(posedge CLK) begin
    if (rst) begin
      rx_block_q    <= 1'b0;
      rx_wait_run_q <= 1'b0;
      rx_wait_cnt_q <= 16'h0000;
    end else if (cmd_go && w_code == CMD_RX_BLOCK) begin
      rx_block_q    <= 1'b1;
      rx_wait_run_q <= 1'b0;
    end else if (cmd_go && w_code == CMD_RX_ENABLE) begin
      rx_block_q    <= 1'b0;
      rx_wait_run_q <= 1'b0;
    end else if (rx_block_q && TX_DONE && tx_busy_q) begin
      if (rx_wait_q == RST_BYTE) rx_block_q <= 1'b0;
      else begin
        rx_wait_run_q <= 1'b1;
        rx_wait_cnt_q <= 16'(rx_wait_q * RX_WAIT_UNIT_CYC - 1);
      end
    end else if (rx_wait_run_q) begin
      if (rx_wait_cnt_q == 16'h0000) begin
        rx_block_q    <= 1'b0;
        rx_wait_run_q <= 1'b0;
      end else rx_wait_cnt_q <= rx_wait_cnt_q - 16'h0001;
    end
  end
  assign RX_RESET = rx_block_q;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Register selected by direct index or pointer
  always_comb begin
    logic [5:0] sel;
    sel = (idx == IDX_DATA) ? {1'b0, ptr_q} : idx;
    unique case (sel)
      IDX_RX_WAIT:   rd_byte = rx_wait_q;
      IDX_IRQ:       rd_byte = irq_q;
      IDX_COLL_POS:  rd_byte = coll_pos_q;
      IDX_RSSI:      rd_byte = rssi_q;
      IDX_LOW_FIELD: rd_byte = low_field_q;
      IDX_HOST_WORD: rd_byte = {1'b0, ptr_rd_q, ptr_cont_q, ptr_q};
      IDX_STATUS:    rd_byte = {2'h0, rx_wait_run_q, tx_pend_q, tx_busy_q, crc_q,
                                rx_block_q, ca.rf_on};
      default:       rd_byte = RST_BYTE;
    endcase
  end
  assign PRDATA = {24'h000000, rd_byte};

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence block_cmd_s;
    cmd_go && w_code == CMD_RX_BLOCK;
  endsequence
  sequence enable_cmd_s;
    cmd_go && w_code == CMD_RX_ENABLE;
  endsequence

  rx_block_hold_a: assert property (@(posedge CLK) disable iff (rst)
    block_cmd_s |=> RX_RESET) else $error("receiver not held after block");
  rx_enable_a: assert property (@(posedge CLK) disable iff (rst)
    enable_cmd_s |=> !RX_RESET) else $error("receiver not released by enable");
  rx_wait_keep_a: assert property (@(posedge CLK) disable iff (rst)
    (rx_block_q && TX_DONE && tx_busy_q && rx_wait_q != RST_BYTE && !cmd_go)
      |=> RX_RESET [*2]) else $error("receiver released before wait time");
  irq_clear_a: assert property (@(posedge CLK) disable iff (rst)
    (irq_rd && !ca.done && !ca.fail) |=> !IRQ) else $error("interrupt kept after read");
  col_err_set_a: assert property (@(posedge CLK) disable iff (rst)
    ca.fail |=> irq_q[IRQ_COL_ERR_BIT] && IRQ) else $error("failure flag missing");
  unknown_ignore_a: assert property (@(posedge CLK) disable iff (rst)
    (word_go && w_is_cmd && !w_cmd_ok && !TX_START && !TX_DONE && !rx_wait_run_q) |=>
      $stable(rx_block_q) && $stable(tx_pend_q) && !FIFO_CLEAR && !CHIP_INIT)
      else $error("unknown command changed state");
  tx_immediate_a: assert property (@(posedge CLK) disable iff (rst)
    (tx_pend_q && !tx_delay_q && FIFO_HAS_DATA && !cmd_go) |=> !tx_pend_q && tx_busy_q)
    else $error("immediate transmission not started");
  tx_delayed_a: assert property (@(posedge CLK) disable iff (rst)
    (tx_pend_q && tx_delay_q && !TX_TIMER_EXPIRED) |-> !TX_START ##1 tx_pend_q)
    else $error("delayed transmission started early");
  reset_cmd_a: assert property (@(posedge CLK) disable iff (rst)
    (cmd_go && w_code == CMD_RESET) |=> FIFO_CLEAR && coll_pos_q == RST_BYTE)
    else $error("reset command left FIFO or position");

endmodule : reader_direct_command_decoder
`default_nettype wire

// *** design/reader_cmd_pkg.sv ***
// Purpose: Shared constants and types of the direct command decoder
// Assumes: 250 MHz system clock
// Notes:   Register indices are word indices; byte address is index times four
package reader_cmd_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int INIT_WAIT_MS  = 5;
  localparam int RESP_WAIT_US  = 75;
  localparam int INIT_WAIT_CYC = (INIT_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESP_WAIT_CYC = (RESP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAND_SLOT_CYC = 256;
  localparam int RX_WAIT_UNIT_CYC = 16;
  localparam int RF_STEP_MV    = 300;

  // ---------------------------------------------------------------
  // Register indices and reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_RX_WAIT   = 6'h08;
  localparam logic [5:0] IDX_IRQ       = 6'h0c;
  localparam logic [5:0] IDX_COLL_POS  = 6'h0e;
  localparam logic [5:0] IDX_RSSI      = 6'h0f;
  localparam logic [5:0] IDX_LOW_FIELD = 6'h16;
  localparam logic [5:0] IDX_HOST_WORD = 6'h20;
  localparam logic [5:0] IDX_DATA      = 6'h21;
  localparam logic [5:0] IDX_STATUS    = 6'h22;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] RST_LOW_FIELD = 8'h00;

  // Field positions
  localparam int WORD_CMD_BIT  = 7;
  localparam int WORD_READ_BIT = 6;
  localparam int WORD_CONT_BIT = 5;
  localparam int IRQ_COL_BIT   = 1;
  localparam int IRQ_COL_ERR_BIT = 0;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_IDLE       = 5'h00,
    CMD_SOFT_INIT  = 5'h03,
    CMD_CA_INIT    = 5'h04,
    CMD_CA_RESP    = 5'h05,
    CMD_CA_RESP_N0 = 5'h06,
    CMD_RESET      = 5'h0f,
    CMD_TX_NOCRC   = 5'h10,
    CMD_TX_CRC     = 5'h11,
    CMD_DTX_NOCRC  = 5'h12,
    CMD_DTX_CRC    = 5'h13,
    CMD_NEXT_SLOT  = 5'h14,
    CMD_CLOSE_SLOT = 5'h15,
    CMD_RX_BLOCK   = 5'h16,
    CMD_RX_ENABLE  = 5'h17,
    CMD_RF_INT     = 5'h18,
    CMD_RF_EXT     = 5'h19,
    CMD_GAIN_ADJ   = 5'h1a
  } cmd_e;

  // Collision avoidance sequencer states
  typedef enum logic [1:0] {
    CA_IDLE  = 2'b00,
    CA_RAND  = 2'b01,
    CA_FIELD = 2'b11
  } ca_state_e;

  // True for codes of the command set
  function automatic logic cmd_known(input logic [4:0] code);
    unique case (code)
      CMD_IDLE, CMD_SOFT_INIT, CMD_CA_INIT, CMD_CA_RESP, CMD_CA_RESP_N0,
      CMD_RESET, CMD_TX_NOCRC, CMD_TX_CRC, CMD_DTX_NOCRC, CMD_DTX_CRC,
      CMD_NEXT_SLOT, CMD_CLOSE_SLOT, CMD_RX_BLOCK, CMD_RX_ENABLE,
      CMD_RF_INT, CMD_RF_EXT, CMD_GAIN_ADJ: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction : cmd_known

endpackage : reader_cmd_pkg

// *** design/ca_if.sv ***
// Purpose: Carrier between command decoder and collision avoidance timer
// Assumes: One clock domain
// Notes:   done and fail are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface ca_if;
  logic       start;
  logic       long_wait;
  logic       random_delay;
  logic [2:0] ext_level;
  logic [2:0] threshold;
  logic       rf_on;
  logic       done;
  logic       fail;
  modport ctl   (output start, long_wait, random_delay, ext_level, threshold,
                 input rf_on, done, fail);
  modport timer (input start, long_wait, random_delay, ext_level, threshold,
                 output rf_on, done, fail);
endinterface : ca_if
`default_nettype wire

// *** design/host_word_decoder.sv ***
// Purpose: Splits a host word into command or address fields
// Assumes: Word is complete when presented
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module host_word_decoder
  import reader_cmd_pkg::*;
(
  // Host word
  input  wire logic [7:0] word,
  // Decoded fields
  output logic            is_cmd,
  output logic            cmd_ok,
  output logic [4:0]      code,
  output logic            rd,
  output logic            cont
);
  // Field split
  always_comb begin
    is_cmd = word[WORD_CMD_BIT];
    code   = word[4:0];
    rd     = word[WORD_READ_BIT];
    cont   = word[WORD_CONT_BIT];
    cmd_ok = is_cmd && !rd && !cont && cmd_known(code);
  end
endmodule : host_word_decoder
`default_nettype wire

// *** design/collision_timer.sv ***
// Purpose: Times RF collision avoidance and reports its outcome
// Assumes: External level and threshold are steady at start
// Notes:   Field stays on once established until reset
`timescale 1ns/10ps
`default_nettype none
module collision_timer
  import reader_cmd_pkg::*;
#(
  parameter int INIT_CYC = INIT_WAIT_CYC,
  parameter int RESP_CYC = RESP_WAIT_CYC
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  ca_if.timer       ca
);
  ca_state_e   state_q;
  logic [20:0] cnt_q;
  logic [20:0] wait_cyc;
  logic [7:0]  lfsr_q;
  logic        long_q;

  assign wait_cyc = long_q ? 21'(INIT_CYC - 1) : 21'(RESP_CYC - 1);

  // Free running random source
  always_ff @(posedge clk) begin
    if (rst) lfsr_q <= 8'h01;
    else lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= CA_IDLE;
      cnt_q    <= 21'h0;
      long_q   <= 1'b0;
      ca.rf_on <= 1'b0;
      ca.done  <= 1'b0;
      ca.fail  <= 1'b0;
    end else begin
      ca.done <= 1'b0;
      ca.fail <= 1'b0;
      unique case (state_q)
        CA_IDLE: begin
          if (ca.start) begin
            long_q <= ca.long_wait;
            if (ca.ext_level > ca.threshold) begin
              ca.fail <= 1'b1;
            end else if (ca.random_delay && lfsr_q[1:0] != 2'h0) begin
              cnt_q   <= 21'(lfsr_q[1:0] * RAND_SLOT_CYC - 1);
              state_q <= CA_RAND;
            end else begin
              ca.rf_on <= 1'b1;
              cnt_q    <= ca.long_wait ? 21'(INIT_CYC - 1) : 21'(RESP_CYC - 1);
              state_q  <= CA_FIELD;
            end
          end
        end
        CA_RAND: begin
          if (cnt_q == 21'h0) begin
            ca.rf_on <= 1'b1;
            cnt_q    <= wait_cyc;
            state_q  <= CA_FIELD;
          end else cnt_q <= cnt_q - 21'h1;
        end
        CA_FIELD: begin
          if (cnt_q == 21'h0) begin
            ca.done <= 1'b1;
            state_q <= CA_IDLE;
          end else cnt_q <= cnt_q - 21'h1;
        end
        default: state_q <= CA_IDLE;
      endcase
    end
  end

  // Assertions
  field_blocked_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == CA_IDLE && ca.start && ca.ext_level > ca.threshold)
      |=> ca.fail && !$rose(ca.rf_on)) else $error("field raised despite external field");
  done_field_a: assert property (@(posedge clk) disable iff (rst)
    ca.done |-> ca.rf_on && $past(cnt_q) == 21'h0) else $error("done without field");
endmodule : collision_timer
`default_nettype wire

// *** sim/tx_frame_model.sv ***
// Purpose: Transmitter stand-in that ends every frame
// Assumes: TX_START is a one-cycle pulse
// Notes:   Frame lasts LEN cycles, then one TX_DONE pulse
`timescale 1ns/10ps
`default_nettype none
module tx_frame_model #(
  parameter int LEN = 6
)(
  // Clock and frame control
  input  wire logic CLK,
  input  wire logic TX_START,
  output logic      TX_DONE
);
  int cnt = 0;
  initial TX_DONE = 1'b0;
  // Frame countdown, done as it runs out
  always @(posedge CLK) begin
    cnt     <= TX_START ? LEN : (cnt > 0 ? cnt - 1 : 0);
    TX_DONE <= (cnt == 1);
  end
endmodule : tx_frame_model
`default_nettype wire

// *** sim/test_reader_direct_command_decoder.sv ***
// Purpose: Self-checking bench of the direct command decoder
// Assumes: Zero wait APB slave, short collision waits
// Notes:   Random levels from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module test_reader_direct_command_decoder;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, e;
  logic [7:0] PADDR = 0, COLL_POS = 0, r, th;
  logic [31:0] PWDATA = 0, PRDATA;
  logic [2:0] EXT_FIELD_LEVEL = 0;
  logic [11:0] PRIMARY_RF_INPUT = 0, SECONDARY_RF_INPUT = 0, m1, m2;
  logic FIFO_HAS_DATA = 0, TX_TIMER_EXPIRED = 0, COLL_POS_VALID = 0, TX_DONE;
  logic PREADY, PSLVERR, CHIP_INIT, RF_ON, TX_START, TX_WITH_CRC, NEXT_SLOT;
  logic CLOSE_SLOT, EXT_RF_TEST, GAIN_ADJUST, FIFO_CLEAR, RX_RESET, IRQ;
  int num_errors = 0, checked = 0, starts = 0, n;
  int w[3] = '{38, 8, 8};
  int x[3] = '{46, 790, 16};
  reader_direct_command_decoder #(.INIT_CYC(40), .RESP_CYC(10)) dut (.*);
  tx_frame_model far (.CLK(CLK), .TX_START(TX_START), .TX_DONE(TX_DONE));
  initial forever #2 CLK = ~CLK;
  // Counts transmit launches
  always @(posedge CLK) if (TX_START === 1'b1) starts <= starts + 1;
  task chk(input string s, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin @(posedge CLK); n++; end
    if (n >= lim) begin num_errors++; test_done(); end
  endtask : wait_for
  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, d);
    @(posedge CLK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= wr; PADDR <= a; PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1;
    @(posedge CLK);
    wait_for(PREADY, 1'b1, 20);
    r = PRDATA[7:0];
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task cmd(input logic [7:0] c);
    apb(1, 8'h80, c);
    @(posedge CLK);
  endtask : cmd
  task wreg(input logic [4:0] i, input logic [7:0] v);
    apb(1, 8'h80, {3'b000, i});
    apb(1, 8'h84, v);
  endtask : wreg
  task rreg(input logic [4:0] i);
    apb(1, 8'h80, {3'b010, i});
    apb(0, 8'h84, 8'h00);
  endtask : rreg
  function automatic logic [2:0] lvl(input logic [11:0] mv);
    return (mv < 600) ? 3'd1 : (mv >= 2100) ? 3'd7 : 3'(mv / 300);
  endfunction : lvl
  initial begin
    void'($urandom(32'h98ab3e1a));
    repeat (5) @(posedge CLK);
    RESET <= 0;
    // Address word read back, unmapped index refused
    th = 8'($urandom);
    apb(1, 8'h80, {1'b0, th[6:0]});
    apb(0, 8'h80, 8'h00);
    chk("addr word", r, {1'b0, th[6:0]});
    apb(0, 8'hfc, 8'h00);
    chk("pslverr", e, 1);
    $display("register access test done");
    // Field above threshold blocks collision avoidance
    th = 8'($urandom_range(6, 0));
    wreg(5'h16, th);
    EXT_FIELD_LEVEL <= th[2:0] + 3'd1;
    cmd(8'h84);
    wait_for(IRQ, 1'b1, 50);
    chk("rf blocked", RF_ON, 0);
    rreg(5'h0c);
    chk("irq fail", r, 8'h01);
    rreg(5'h0c);
    chk("irq cleared", r, 8'h00);
    chk("irq line", IRQ, 0);
    // Each collision avoidance code after a soft init
    for (int i = 0; i < 3; i++) begin
      cmd(8'h83);
      chk("init pulse", CHIP_INIT, 1);
      @(posedge CLK);
      chk("init field", RF_ON, 0);
      wreg(5'h16, th);
      EXT_FIELD_LEVEL <= th[2:0];
      cmd(8'h84 + 8'(i));
      wait_for(IRQ, 1'b1, 1000);
      chk("ca wait", (n >= w[i] && n <= x[i]), 1);
      chk("field on", RF_ON, 1);
      rreg(5'h0c);
      chk("irq done", r, 8'h02);
    end
    $display("collision avoidance test done");
    // Ignored words leave the state at reset
    cmd(8'h83);
    foreach (x[i]) cmd(8'h9b + 8'(i));
    cmd(8'hd6);
    cmd(8'hb6);
    apb(0, 8'h88, 8'h00);
    chk("ignored", r, 8'h00);
    // Receiver block, enable, end of transmit
    cmd(8'h96);
    chk("rx block", RX_RESET, 1);
    cmd(8'h97);
    chk("rx enable", RX_RESET, 0);
    cmd(8'h96);
    cmd(8'h91);
    repeat (4) @(posedge CLK);
    chk("no data", 8'(starts), 0);
    FIFO_HAS_DATA <= 1;
    wait_for(RX_RESET, 1'b0, 50);
    chk("started", 8'(starts), 1);
    chk("crc", TX_WITH_CRC, 1);
    wreg(5'h08, 8'h02);
    cmd(8'h96);
    cmd(8'h90);
    wait_for(RX_RESET, 1'b0, 100);
    chk("rx wait", n >= 32, 1);
    chk("no crc", TX_WITH_CRC, 0);
    // Delayed transmission waits for the transmit timer
    cmd(8'h93);
    repeat (4) @(posedge CLK);
    chk("delayed", 8'(starts), 2);
    TX_TIMER_EXPIRED <= 1;
    repeat (2) @(posedge CLK);
    chk("timer start", 8'(starts), 3);
    TX_TIMER_EXPIRED <= 0;
    $display("receiver test done");
    // Internal RF levels into the level register
    repeat (4) begin
      m1 = 12'($urandom_range(2400, 0));
      m2 = 12'($urandom_range(2400, 0));
      PRIMARY_RF_INPUT <= m1;
      SECONDARY_RF_INPUT <= m2;
      cmd(8'h97);
      cmd(8'h98);
      rreg(5'h0f);
      chk("rssi", r, {2'b00, lvl(m2), lvl(m1)});
    end
    $display("rf level test done");
    // Collision position by a continuous read, then the reset command
    COLL_POS <= 8'($urandom) | 8'h01;
    COLL_POS_VALID <= 1;
    @(posedge CLK);
    COLL_POS_VALID <= 0;
    apb(1, 8'h80, 8'h6e);
    apb(0, 8'h84, 8'h00);
    chk("coll pos set", r, COLL_POS);
    apb(0, 8'h84, 8'h00);
    chk("cont read", r, {2'b00, lvl(m2), lvl(m1)});
    cmd(8'h8f);
    chk("fifo clear", FIFO_CLEAR, 1);
    rreg(5'h0e);
    chk("coll pos", r, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cmd(i < 2 ? 8'h94 + 8'(i) : 8'h97 + 8'(i));
      chk("strobe", {NEXT_SLOT, CLOSE_SLOT, EXT_RF_TEST, GAIN_ADJUST}, 8'h8 >> i);
    end
    $display("command strobe test done");
    test_done();
  end
endmodule : test_reader_direct_command_decoder
`default_nettype wire
